// ---- logic/spg_pkg.sv ----
package spg_pkg;
	localparam int AXES = 2;
	localparam int CNT_W = 11;
	localparam int MULT_W = 8;
	localparam int ACC_W = 28;
	localparam int RAMP_W = 20;
	localparam int WID_W = 8;
	localparam int LIM_N = 5;
	localparam int FIFO_DEPTH = 512;
	localparam int PTR_W = 9;
	localparam int LVL_W = 10;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int BASE_PERIOD_NS = 8192000;
	localparam int BASE_CYCLES = BASE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PULSE_WIDTH_NS = 2000;
	localparam int PULSE_CYCLES = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [MULT_W-1:0] MULT_MIN = 8'h01;
	localparam logic [MULT_W-1:0] MULT_MAX = 8'hfe;
	// byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_MULT = 8'h04;
	localparam logic [7:0] ADR_ACCEL = 8'h08;
	localparam logic [7:0] ADR_SLOW = 8'h0c;
	localparam logic [7:0] ADR_CMD = 8'h10;
	localparam logic [7:0] ADR_STAT = 8'h14;
	// reset values
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [MULT_W-1:0] MULT_RST = 8'h01;
	localparam logic [CNT_W-1:0] ACCEL_RST = 11'h000;
	localparam logic [CNT_W-1:0] SLOW_RST = 11'h064;
	// control fields: run, then per axis two-line and negative polarity
	localparam int CTRL_RUN = 0;
	localparam int CTRL_TWO0 = 1;
	localparam int CTRL_NEG0 = 2;
	// command word fields
	localparam int CMD_DIR0 = 22;
	localparam int CMD_DUR_LSB = 24;
	// status fields
	localparam int ST_FULL = 10;
	localparam int ST_EMPTY = 11;
	localparam int ST_BUSY = 12;
	localparam int ST_OVF = 13;
	localparam int ST_LIM_LSB = 14;
	// switch order inside one axis group
	localparam int LIM_FEND = 1;
	localparam int LIM_REND = 2;
	localparam int LIM_FSLOW = 3;
	localparam int LIM_RSLOW = 4;
	typedef enum logic {SEQ_IDLE, SEQ_RUN} spg_seq_type;
endpackage

// ---- logic/spg_axis_if.sv ----
`timescale 1ns/10ps
interface spg_axis_if import spg_pkg::*; ();
	logic start;
	logic [CNT_W-1:0] count;
	logic dir;
	logic halt;
	logic twoLine;
	logic negPol;
	logic [ACC_W-1:0] periodLen;
	logic lineA;
	logic lineB;
	modport ctl (output start, count, dir, halt, twoLine, negPol, periodLen, input lineA, lineB);
	modport ax (input start, count, dir, halt, twoLine, negPol, periodLen, output lineA, lineB);
endinterface

// ---- logic/spg_pulse_spread_integrator.sv ----
`timescale 1ns/10ps
module spg_pulse_spread_integrator
	import spg_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic srst, // sync reset
	input wire logic ce, // clock enable
	spg_axis_if.ax ax // settings in, lines out
);
	logic [ACC_W-1:0] acc_q, acc_d;
	logic [WID_W-1:0] wid_q, wid_d;
	logic lineA_q, lineA_d, lineB_q, lineB_d;
	logic [ACC_W:0] sum;
	logic fire, pulse;
	logic [CNT_W-1:0] pc_q, lastCnt_q;
	logic seen_q;

	// integrator: add count per tick, fire on crossing the period length
	always_comb
	begin
		sum = ax.start ? (ACC_W+1)'(ax.count) : {1'b0, acc_q} + (ACC_W+1)'(ax.count);
		fire = sum >= {1'b0, ax.periodLen}; // R1
		acc_d = fire ? ACC_W'(sum - {1'b0, ax.periodLen}) : ACC_W'(sum);
		if (fire && !ax.halt) // R10
			wid_d = WID_W'(PULSE_CYCLES);
		else
			wid_d = (wid_q != '0) ? wid_q - 8'h01 : wid_q;
		pulse = wid_d != '0;
		if (ax.twoLine) // R4
		begin
			lineA_d = (pulse & ~ax.dir) ^ ax.negPol; // R5
			lineB_d = (pulse & ax.dir) ^ ax.negPol;
		end
		else
		begin
			lineA_d = pulse ^ ax.negPol; // R5
			lineB_d = ax.dir;
		end
	end

	// state registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			acc_q <= '0;
			wid_q <= '0;
			lineA_q <= 1'b0;
			lineB_q <= 1'b0;
		end
		else if (ce)
		begin
			acc_q <= acc_d;
			wid_q <= wid_d;
			lineA_q <= lineA_d;
			lineB_q <= lineB_d;
		end
	end

	assign ax.lineA = lineA_q;
	assign ax.lineB = lineB_q;

	// helper: crossings counted per period for checking
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pc_q <= '0;
			lastCnt_q <= '0;
			seen_q <= 1'b0;
		end
		else if (ce)
		begin
			pc_q <= ax.start ? CNT_W'(fire) : pc_q + CNT_W'(fire);
			if (ax.start)
			begin
				lastCnt_q <= ax.count;
				seen_q <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || !ce);

	a_pulse_exact_count: assert property (ax.start && seen_q |-> pc_q == lastCnt_q) // R1
		else $error("pulse count in period differs from programmed count");
	a_idle_pol_level: assert property (wid_q == '0 && $past(ce) |-> lineA_q == $past(ax.negPol)) // R5
		else $error("idle step line not at inactive polarity");
	a_dir_line_mode: assert property ($past(ce) && !$past(ax.twoLine) |-> lineB_q == $past(ax.dir)) // R4
		else $error("direction line wrong in pulse plus direction mode");
	a_halt_no_pulse: assert property (ax.halt |=> !$rose(wid_q != '0)) // R10
		else $error("pulse started while halted by end limit");
	a_zero_no_pulse: assert property (ax.count == '0 && !ax.start |-> !fire) // R3
		else $error("crossing with zero count");
endmodule

// ---- logic/spg_step_pulse_top.sv ----
`timescale 1ns/10ps
// Contract
// R1: each period emits exactly the programmed pulse count, evenly spaced
// R2: period equals multiplier times 8.192 ms base, multiplier 1 to 254
// R3: pulse count per period is 11 bits, 0 to 2047, zero gives none
// R4: each axis selects two-line cw/ccw or step plus direction output
// R5: step output polarity is programmable positive or negative
// R6: two axes run independently and simultaneously with own settings
// R7: rate ramps up linearly, holds, ramps down linearly: trapezoid
// R8: each axis watches home, two end limits and two high-speed limits
// R9: commands queue in a 2 KiB FIFO; host stops writing when full
// R10: end limit stops pulses in that direction; high-speed limit caps rate
module spg_step_pulse_top
	import spg_pkg::*;
#(
	parameter int BASE_CYCLES_P = BASE_CYCLES
)
(
	input wire logic clk, // 100 MHz clock
	input wire logic srst, // sync reset
	input wire logic ce, // clock enable
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	input wire logic [AXES*LIM_N-1:0] limitPin, // switch pins
	output logic [AXES-1:0] stepA, // cw or step line
	output logic [AXES-1:0] stepB // ccw or direction line
);
	spg_axis_if axIf [AXES] ();

	logic [4:0] ctrl_q, ctrl_d;
	logic [MULT_W-1:0] mult_q, mult_d;
	logic [CNT_W-1:0] accel_q, accel_d, slow_q, slow_d;
	logic ovf_q, ovf_d, ack_q, ack_d;
	logic [31:0] dat_q, dat_d;
	logic [AXES*LIM_N-1:0] limS1_q, limS2_q;
	logic [31:0] mem_q [FIFO_DEPTH];
	logic [PTR_W-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [LVL_W-1:0] lvl_q, lvl_d;
	logic full, empty, req, wrCmd, push, pop;
	logic [ACC_W-1:0] prd_q, prd_d, plen_q, plen_d;
	logic start_q, boundary;
	spg_seq_type state_q, state_d;
	logic [31:0] cmd_q, cmd_d;
	logic [MULT_W-1:0] left_q, left_d, k_q, k_d, effMult;

	function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			lanes[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
	endfunction

	// switch inputs pass two flops before use
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			limS1_q <= '0;
			limS2_q <= '0;
		end
		else if (ce)
		begin
			limS1_q <= limitPin; // R8
			limS2_q <= limS1_q;
		end
	end

	// bus slave: one-cycle ack, lane-masked register writes, command pushes take all 32 bits, unmapped reads zero
	always_comb
	begin
		req = wb_cyc_i && wb_stb_i && !ack_q;
		ack_d = req;
		wrCmd = req && wb_we_i && wb_adr_i == ADR_CMD;
		push = wrCmd && !full; // R9
		ctrl_d = ctrl_q;
		mult_d = mult_q;
		accel_d = accel_q;
		slow_d = slow_q;
		ovf_d = ovf_q;
		dat_d = dat_q;
		if (req && wb_we_i)
		begin
			case (wb_adr_i)
				ADR_CTRL: ctrl_d = 5'(lanes(32'(ctrl_q), wb_dat_i, wb_sel_i));
				ADR_MULT: mult_d = 8'(lanes(32'(mult_q), wb_dat_i, wb_sel_i));
				ADR_ACCEL: accel_d = 11'(lanes(32'(accel_q), wb_dat_i, wb_sel_i));
				ADR_SLOW: slow_d = 11'(lanes(32'(slow_q), wb_dat_i, wb_sel_i));
				ADR_STAT: if (wb_sel_i[1] && wb_dat_i[ST_OVF]) ovf_d = 1'b0;
				default: ;
			endcase
		end
		if (wrCmd && full) // set wins over clear
			ovf_d = 1'b1;
		if (req && !wb_we_i)
		begin
			case (wb_adr_i)
				ADR_CTRL: dat_d = 32'(ctrl_q);
				ADR_MULT: dat_d = 32'(mult_q);
				ADR_ACCEL: dat_d = 32'(accel_q);
				ADR_SLOW: dat_d = 32'(slow_q);
				ADR_STAT: dat_d = {8'h00, limS2_q, ovf_q, state_q == SEQ_RUN, empty, full, lvl_q};
				default: dat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_q <= CTRL_RST;
			mult_q <= MULT_RST;
			accel_q <= ACCEL_RST;
			slow_q <= SLOW_RST;
			ovf_q <= 1'b0;
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else if (ce)
		begin
			ctrl_q <= ctrl_d;
			mult_q <= mult_d;
			accel_q <= accel_d;
			slow_q <= slow_d;
			ovf_q <= ovf_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// command FIFO pointers and level
	always_comb
	begin
		full = lvl_q == LVL_W'(FIFO_DEPTH);
		empty = lvl_q == '0;
		wrPtr_d = push ? wrPtr_q + 9'h001 : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + 9'h001 : rdPtr_q;
		lvl_d = lvl_q + LVL_W'(push) - LVL_W'(pop); // R9
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			lvl_q <= '0;
		end
		else if (ce)
		begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			lvl_q <= lvl_d;
		end
	end

	// storage: write only, reset not needed
	always_ff @(posedge clk)
	begin
		if (ce && push)
			mem_q[wrPtr_q] <= wb_dat_i; // R9
	end

	// period timer and move sequencer
	always_comb
	begin
		effMult = mult_q;
		if (mult_q < MULT_MIN)
			effMult = MULT_MIN;
		else if (mult_q > MULT_MAX)
			effMult = MULT_MAX;
		boundary = prd_q == plen_q - 28'h000_0001;
		prd_d = boundary ? '0 : prd_q + 28'h000_0001;
		plen_d = boundary ? ACC_W'(effMult) * ACC_W'(BASE_CYCLES_P) : plen_q; // R2
		state_d = state_q;
		cmd_d = cmd_q;
		left_d = left_q;
		k_d = k_q;
		pop = 1'b0;
		if (boundary)
		begin
			if (left_q != '0)
			begin
				left_d = left_q - 8'h01;
				k_d = k_q + 8'h01;
			end
			else if (ctrl_q[CTRL_RUN] && !empty)
			begin
				pop = 1'b1; // R9
				cmd_d = mem_q[rdPtr_q];
				left_d = (mem_q[rdPtr_q][31:CMD_DUR_LSB] == '0) ? '0 : mem_q[rdPtr_q][31:CMD_DUR_LSB] - 8'h01;
				k_d = '0;
				state_d = SEQ_RUN;
			end
			else
				state_d = SEQ_IDLE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			prd_q <= '0;
			plen_q <= ACC_W'(BASE_CYCLES_P);
			start_q <= 1'b0;
			state_q <= SEQ_IDLE;
			cmd_q <= '0;
			left_q <= '0;
			k_q <= '0;
		end
		else if (ce)
		begin
			prd_q <= prd_d;
			plen_q <= plen_d;
			start_q <= boundary;
			state_q <= state_d;
			cmd_q <= cmd_d;
			left_q <= left_d;
			k_q <= k_d;
		end
	end

	// per axis: ramp, limits, latched settings, integrator
	for (genvar g = 0; g < AXES; g++)
	begin : gAxis
		logic [CNT_W-1:0] cnt_q, cnt_d;
		logic dir_q, dir_d, two_q, two_d, neg_q, neg_d;
		logic [RAMP_W-1:0] up, dn;
		logic [CNT_W-1:0] target;
		logic endLim, slowLim;

		always_comb
		begin
			target = cmd_d[g*CNT_W +: CNT_W]; // R3
			dir_d = boundary ? cmd_d[CMD_DIR0+g] : dir_q;
			two_d = boundary ? ctrl_q[CTRL_TWO0+2*g] : two_q;
			neg_d = boundary ? ctrl_q[CTRL_NEG0+2*g] : neg_q;
			endLim = dir_q ? limS2_q[g*LIM_N+LIM_REND] : limS2_q[g*LIM_N+LIM_FEND];
			slowLim = dir_d ? limS2_q[g*LIM_N+LIM_RSLOW] : limS2_q[g*LIM_N+LIM_FSLOW];
			up = RAMP_W'(accel_q) * RAMP_W'({1'b0, k_d} + 9'h001);
			dn = RAMP_W'(accel_q) * RAMP_W'({1'b0, left_d} + 9'h001);
			cnt_d = cnt_q;
			if (boundary)
			begin
				cnt_d = target;
				if (accel_q != '0 && up < RAMP_W'(cnt_d)) // R7
					cnt_d = CNT_W'(up);
				if (accel_q != '0 && dn < RAMP_W'(cnt_d)) // R7
					cnt_d = CNT_W'(dn);
				if (slowLim && slow_q < cnt_d) // R10
					cnt_d = slow_q;
				if (state_d != SEQ_RUN)
					cnt_d = '0;
			end
		end

		always_ff @(posedge clk)
		begin
			if (srst)
			begin
				cnt_q <= '0;
				dir_q <= 1'b0;
				two_q <= 1'b0;
				neg_q <= 1'b0;
			end
			else if (ce)
			begin
				cnt_q <= cnt_d;
				dir_q <= dir_d;
				two_q <= two_d;
				neg_q <= neg_d;
			end
		end

		assign axIf[g].start = start_q;
		assign axIf[g].count = cnt_q;
		assign axIf[g].dir = dir_q;
		assign axIf[g].halt = endLim; // R10
		assign axIf[g].twoLine = two_q;
		assign axIf[g].negPol = neg_q;
		assign axIf[g].periodLen = plen_q;
		assign stepA[g] = axIf[g].lineA;
		assign stepB[g] = axIf[g].lineB;

		spg_pulse_spread_integrator uInt // R6
		(
			.clk(clk),
			.srst(srst),
			.ce(ce),
			.ax(axIf[g])
		);

		a_ramp_up_bound: assert property (@(posedge clk) disable iff (srst || !ce) // R7
			start_q && accel_q == $past(accel_q) && accel_q != '0 |-> RAMP_W'(cnt_q) <= RAMP_W'(accel_q) * RAMP_W'({1'b0, k_q} + 9'h001))
			else $error("ramp exceeded linear bound");
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || !ce);

	sequence sWriteFull;
		wrCmd && full;
	endsequence
	a_fifo_full_hold: assert property (sWriteFull |=> ovf_q && lvl_q <= $past(lvl_q)) // R9
		else $error("write accepted while FIFO full");
	// a pop only at a boundary with work queued, the new period starting next
	sequence sPopStart;
		boundary && !empty ##1 start_q;
	endsequence
	a_pop_on_boundary: assert property (pop |-> sPopStart) // R9
		else $error("command popped off a period boundary");
	a_period_range: assert property (start_q |-> plen_q >= ACC_W'(BASE_CYCLES_P) // R2
		&& plen_q <= ACC_W'(MULT_MAX) * ACC_W'(BASE_CYCLES_P) && plen_q % ACC_W'(BASE_CYCLES_P) == '0)
		else $error("period length not a multiple of base within range");
	a_limit_sync_delay: assert property ($past(ce) && $past(ce, 2) && !$past(srst) && !$past(srst, 2) // R8
		|-> limS2_q == $past(limitPin, 2))
		else $error("switch inputs not passed through two flops");
endmodule

// ---- verif/spg_drive_model.sv ----
`timescale 1ns/10ps
// drive stages and switch panel: counts pulses, presents switch levels
module spg_drive_model
	import spg_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic clr, // clear counts
	input wire logic [AXES-1:0] neg, // pulses active low
	input wire logic [AXES*LIM_N-1:0] sw, // switch states
	input wire logic [AXES-1:0] stepA, // cw or step line
	input wire logic [AXES-1:0] stepB, // ccw or direction line
	output logic [AXES*LIM_N-1:0] limitPin, // switch pins
	output logic [15:0] cntA [AXES], // pulses seen on A
	output logic [15:0] cntB [AXES] // pulses seen on B
);
	logic [AXES-1:0] prevA;
	logic [AXES-1:0] prevB;
	// switches are plain held levels
	assign limitPin = sw;
	// one count per pulse, on its leading edge away from idle
	always_ff @(posedge clk)
	begin
		prevA <= stepA ^ neg;
		prevB <= stepB ^ neg;
		for (int g = 0; g < AXES; g++)
		begin
			cntA[g] <= clr ? 16'h0000 : cntA[g] + 16'((stepA[g] ^ neg[g]) & ~prevA[g]);
			cntB[g] <= clr ? 16'h0000 : cntB[g] + 16'((stepB[g] ^ neg[g]) & ~prevB[g]);
		end
	end
endmodule

// ---- verif/spg_step_pulse_top_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module spg_step_pulse_top_tb_top
	import spg_pkg::*;
;
	localparam int BASE = 2000;
	logic clk;
	logic srst;
	logic ce;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat;
	logic [31:0] rdo;
	logic ack;
	logic [AXES-1:0] stepA;
	logic [AXES-1:0] stepB;
	logic [AXES-1:0] neg;
	logic [AXES*LIM_N-1:0] sw;
	logic [AXES*LIM_N-1:0] limitPin;
	logic clr;
	logic [15:0] cntA [AXES];
	logic [15:0] cntB [AXES];
	logic [31:0] rdat;
	logic [AXES-1:0] dirSeen;
	logic [15:0] winCnt;
	int n_fail;
	int check_count;

	spg_step_pulse_top #(.BASE_CYCLES_P(BASE)) DUT (.clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo),
		.wb_ack_o(ack), .limitPin(limitPin), .stepA(stepA), .stepB(stepB));
	spg_drive_model drive (.clk(clk), .clr(clr), .neg(neg), .sw(sw), .stepA(stepA), .stepB(stepB),
		.limitPin(limitPin), .cntA(cntA), .cntB(cntB));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// one classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		// wait for the answer; only the watchdog ends a hang
		do
			@(posedge clk);
		while (ack !== 1'b1);
		rdat = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// set format, let a boundary pass, push one move, wait for it to end
	task automatic run_move(input logic [31:0] ctl, input logic [31:0] cmd, input int w);
		int t;
		wb(1'b1, ADR_CTRL, ctl);
		repeat (BASE + 20) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wb(1'b1, ADR_CMD, cmd);
		t = 0;
		while ((cntA[0] | cntA[1] | cntB[0]) == 16'h0000 && t < 4 * BASE)
		begin
			@(posedge clk);
			t++;
		end
		dirSeen = stepB;
		repeat (w) @(posedge clk);
		winCnt = cntA[0];
		t = 0;
		do
		begin
			wb(1'b0, ADR_STAT, 32'h0);
			repeat (20) @(posedge clk);
			t++;
		end
		while (rdat[12:11] !== 2'b01 && t < 2000);
		`CHK(rdat[12:11], 2'b01)
		repeat (300) @(posedge clk);
	endtask

	task automatic t_regs;
		wb(1'b0, ADR_MULT, 32'h0);
		`CHK(rdat, 32'h0000_0001)
		wb(1'b0, ADR_SLOW, 32'h0);
		`CHK(rdat, 32'h0000_0064)
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat, 32'h0000_0800)
		wb(1'b0, 8'h18, 32'h0);
		`CHK(rdat, 32'h0000_0000)
		sel <= 4'he;
		wb(1'b1, ADR_MULT, 32'h5);
		sel <= 4'hf;
		wb(1'b0, ADR_MULT, 32'h0);
		`CHK(rdat, 32'h0000_0001)
	endtask

	// frozen clock enable holds the bus answer and the switch flops
	task automatic t_freeze;
		ce <= 1'b0;
		sw <= 10'h010;
		fork
			wb(1'b0, ADR_STAT, 32'h0);
			begin
				repeat (10) @(posedge clk);
				`CHK(ack, 1'b0)
				ce <= 1'b1;
			end
		join
		`CHK(rdat[23:14], 10'h000)
		repeat (5) @(posedge clk);
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat[23:14], 10'h010)
		sw <= 10'h000;
		repeat (5) @(posedge clk);
	endtask

	task automatic t_basic;
		run_move(32'h1, {8'h01, 1'h1, 1'h0, 11'h003, 11'h005}, 0);
		`CHK(cntA[0], 16'h0005)
		`CHK(cntA[1], 16'h0003)
		`CHK(dirSeen, 2'b10)
	endtask

	task automatic t_twoline;
		neg <= 2'b01;
		run_move(32'hf, {8'h01, 1'h0, 1'h1, 11'h000, 11'h004}, 0);
		`CHK(cntB[0], 16'h0004)
		`CHK(cntA[0], 16'h0000)
		`CHK(cntA[1] | cntB[1], 16'h0000)
		`CHK({stepA[0], stepB[0]}, 2'b11)
		neg <= 2'b00;
	endtask

	// forward end on axis 0, forward slow on axis 1
	task automatic t_limit;
		sw <= 10'h102;
		wb(1'b1, ADR_SLOW, 32'h2);
		repeat (5) @(posedge clk);
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat[23:14], 10'h102)
		run_move(32'h1, {8'h01, 2'h0, 11'h006, 11'h005}, 0);
		`CHK(cntA[0], 16'h0000)
		`CHK(cntA[1], 16'h0002)
		sw <= 10'h000;
		wb(1'b1, ADR_SLOW, 32'h64);
	endtask

	// slope 2 over four periods: 2, 4, 4, 2
	task automatic t_ramp;
		wb(1'b1, ADR_ACCEL, 32'h2);
		run_move(32'h1, {8'h04, 2'h0, 11'h000, 11'h006}, 0);
		`CHK(cntA[0], 16'h000c)
		wb(1'b1, ADR_ACCEL, 32'h0);
	endtask

	// pulses seen in a window after the first one show spacing
	task automatic t_mult;
		run_move(32'h1, {8'h01, 2'h0, 11'h000, 11'h004}, 1300);
		`CHK(winCnt, 16'h0003)
		wb(1'b1, ADR_MULT, 32'h2);
		run_move(32'h1, {8'h01, 2'h0, 11'h000, 11'h004}, 1300);
		`CHK(winCnt, 16'h0002)
		`CHK(cntA[0], 16'h0004)
		wb(1'b1, ADR_MULT, 32'h0);
		run_move(32'h1, {8'h01, 2'h0, 11'h000, 11'h004}, 1300);
		`CHK(winCnt, 16'h0003)
		wb(1'b1, ADR_MULT, 32'h1);
	endtask

	// fill while stopped, push once more, clear overflow, reset empties
	task automatic t_fifo;
		wb(1'b1, ADR_CTRL, 32'h0);
		repeat (FIFO_DEPTH) wb(1'b1, ADR_CMD, 32'h0);
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat[13:0], 14'h0600)
		wb(1'b1, ADR_CMD, 32'h0);
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat[13], 1'b1)
		wb(1'b1, ADR_STAT, 32'h2000);
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat[13], 1'b0)
		srst <= 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		wb(1'b0, ADR_STAT, 32'h0);
		`CHK(rdat[13:10], 4'h2)
	endtask

	// watchdog
	initial
	begin
		repeat (80000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end

	// main sequence
	initial
	begin
		n_fail = 0;
		check_count = 0;
		srst = 1'b1;
		ce = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		dat = 32'h0;
		neg = 2'b00;
		sw = 10'h000;
		clr = 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		clr <= 1'b0;
		t_regs;
		t_freeze;
		t_basic;
		t_twoline;
		t_limit;
		t_ramp;
		t_mult;
		t_fifo;
		report_and_stop;
	end
endmodule
